// *** rtl/ohpp_map.svh ***
// constants for the parallel host port
`ifndef OHPP_MAP_SVH
`define OHPP_MAP_SVH
`define OHPP_DATA_W     8
`define OHPP_FIFO_DEPTH 4
`define OHPP_SEL_SPI3   2'b01
`define OHPP_SEL_SPI4   2'b00
`define OHPP_SEL_P68    2'b11
`define OHPP_SEL_P80    2'b10
`define OHPP_RD_RESET   8'h00
`endif

// *** rtl/ohpp_pkg.sv ***
// types for the parallel host port
package ohpp_pkg;
	typedef enum logic [1:0] {
		OHPP_MODE_SPI3,
		OHPP_MODE_SPI4,
		OHPP_MODE_P68,
		OHPP_MODE_P80
	} ohpp_mode_t;
endpackage

// *** rtl/ohpp_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ohpp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	wire              push;
	wire              pop;
	wire  [AW-1:0]    nxt_wr_ptr;
	wire  [AW-1:0]    nxt_rd_ptr;

	// handshakes and pointer wrap
	assign o_in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign o_out_valid = (count_ff != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign nxt_wr_ptr  = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
	assign nxt_rd_ptr  = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
	assign o_out_data  = mem_ff[rd_ptr_ff];

	// storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= i_in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= nxt_wr_ptr;
			end
			if (pop) begin
				rd_ptr_ff <= nxt_rd_ptr;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

// *** rtl/ohpp_port.sv ***
// device-side decoder of the 68xx/80xx parallel host port
// How it works
// RULE1: data/command select high marks the written byte as display data.
// RULE2: data/command select low routes the written byte to the command register.
// RULE3: 68xx cycle starts when enable rises while chip select is low.
// RULE4: 68xx direction high means read, low means write.
// RULE5: 80xx read starts on read strobe low with chip select low; drive bus.
// RULE6: 80xx write starts on write strobe low with chip select low; take byte.
// RULE7: in serial modes the host ties the enable/read strobe low.
// RULE8: in serial modes the host ties the direction/write strobe low.
// RULE9: bus activity is ignored unless chip select is low.
// RULE10: two select pins choose spi3, spi4, 68xx or 80xx.
// RULE11: host keeps data/command and direction steady during a strobe.
`timescale 1ns/10ps
`include "ohpp_map.svh"
module ohpp_port #(
	parameter int DATA_W     = `OHPP_DATA_W,
	parameter int FIFO_DEPTH = `OHPP_FIFO_DEPTH
) (
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	input  wire logic              i_interface_select_a,
	input  wire logic              i_interface_select_b,
	input  wire logic              i_cs_n,
	input  wire logic              i_dc,
	input  wire logic              i_strobe_e_rd,
	input  wire logic              i_strobe_rw_wr,
	input  wire logic [DATA_W-1:0] i_host_data_bus,
	output logic      [DATA_W-1:0] o_host_data_bus,
	output logic                   o_host_data_bus_oe,
	input  wire logic [DATA_W-1:0] i_read_data,
	output logic                   o_read_req,
	output logic                   o_read_is_data,
	output logic                   o_cmd_valid,
	output logic      [DATA_W-1:0] o_cmd_byte,
	output logic                   o_pix_valid,
	input  wire logic              i_pix_ready,
	output logic      [DATA_W-1:0] o_pix_byte,
	output logic                   o_wr_overflow,
	output ohpp_pkg::ohpp_mode_t   o_mode
);
	import ohpp_pkg::*;

	// three-stage synchronisers: stage 1 feeds only stage 2
	logic [2:0]        s1_ff;
	logic [2:0]        s2_ff;
	logic [2:0]        s3_ff;
	logic [2:0]        stb_ff;
	logic [DATA_W-1:0] d1_ff;
	logic [DATA_W-1:0] d2_ff;
	logic [DATA_W-1:0] d3_ff;
	logic [1:0]        bs1_ff;
	logic [1:0]        bs2_ff;
	logic [1:0]        bs3_ff;
	logic [1:0]        bs_ff;
	wire  [1:0]        nxt_bs;
	logic              dc1_ff;
	logic              dc2_ff;
	logic              dc3_ff;
	wire  [2:0]        raw_ctl;
	wire  [2:0]        nxt_stb;

	assign raw_ctl = {i_cs_n, i_strobe_e_rd, i_strobe_rw_wr};

	// stable value: update once stages 2 and 3 agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ctl
			assign nxt_stb[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : stb_ff[g];
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			s1_ff  <= 3'h4;
			s2_ff  <= 3'h4;
			s3_ff  <= 3'h4;
			stb_ff <= 3'h4;
		end else begin
			s1_ff  <= raw_ctl;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			stb_ff <= nxt_stb;
		end
	end

	// data, select and data/command pins; select settles when stages 2 and 3 agree, data and d/c are qualified by the stable strobes
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			d1_ff  <= '0;
			d2_ff  <= '0;
			d3_ff  <= '0;
			bs1_ff <= 2'h0;
			bs2_ff <= 2'h0;
			bs3_ff <= 2'h0;
			bs_ff  <= 2'h0;
			dc1_ff <= 1'b0;
			dc2_ff <= 1'b0;
			dc3_ff <= 1'b0;
		end else begin
			d1_ff  <= i_host_data_bus;
			d2_ff  <= d1_ff;
			d3_ff  <= d2_ff;
			bs1_ff <= {i_interface_select_b, i_interface_select_a};
			bs2_ff <= bs1_ff;
			bs3_ff <= bs2_ff;
			bs_ff  <= nxt_bs;
			dc1_ff <= i_dc;
			dc2_ff <= dc1_ff;
			dc3_ff <= dc2_ff;
		end
	end

	// mode decode from the select pins, taken once stages 2 and 3 agree
	wire [1:0]  sel_code;
	ohpp_mode_t nxt_mode;
	assign nxt_bs   = (bs2_ff == bs3_ff) ? bs3_ff : bs_ff;
	assign sel_code = bs_ff;
	assign nxt_mode = (sel_code == `OHPP_SEL_P68)  ? OHPP_MODE_P68 :   // RULE10
	                  (sel_code == `OHPP_SEL_P80)  ? OHPP_MODE_P80 :   // RULE10
	                  (sel_code == `OHPP_SEL_SPI3) ? OHPP_MODE_SPI3 :  // RULE10
	                                                 OHPP_MODE_SPI4;   // RULE10

	// strobe decode; gated by mode, so serial modes ignore both strobes
	wire cs_act;
	wire e_lvl;
	wire rw_lvl;
	wire is68;
	wire is80;
	wire act68;
	wire act80_rd;
	wire act80_wr;
	wire rd_act;
	wire wr_act;
	logic rd_act_ff;
	logic wr_act_ff;
	assign cs_act   = !stb_ff[2];                            // RULE9
	assign e_lvl    = stb_ff[1];
	assign rw_lvl   = stb_ff[0];
	assign is68     = (o_mode == OHPP_MODE_P68);
	assign is80     = (o_mode == OHPP_MODE_P80);
	assign act68    = is68 && cs_act && e_lvl;               // RULE3
	assign act80_rd = is80 && cs_act && !e_lvl;              // RULE5
	assign act80_wr = is80 && cs_act && !rw_lvl && e_lvl;    // RULE6
	assign rd_act   = (act68 && rw_lvl) || act80_rd;         // RULE4
	assign wr_act   = (act68 && !rw_lvl) || act80_wr;        // RULE4

	// a write is taken at the end of its strobe, with data and d/c stable
	wire wr_end;
	wire rd_start;
	wire wr_pix;
	wire wr_cmd;
	wire pix_in_ready;
	assign wr_end   = wr_act_ff && !wr_act;                  // RULE11
	assign rd_start = rd_act && !rd_act_ff;
	assign wr_pix   = wr_end && dc3_ff;                      // RULE1
	assign wr_cmd   = wr_end && !dc3_ff;                     // RULE2

	// strobe history, mode and command outputs
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rd_act_ff      <= 1'b0;
			wr_act_ff      <= 1'b0;
			o_mode         <= OHPP_MODE_SPI4;
			o_cmd_valid    <= 1'b0;
			o_cmd_byte     <= '0;
			o_read_req     <= 1'b0;
			o_read_is_data <= 1'b0;
			o_wr_overflow  <= 1'b0;
		end else begin
			rd_act_ff      <= rd_act;
			wr_act_ff      <= wr_act;
			o_mode         <= nxt_mode;
			o_cmd_valid    <= wr_cmd;                        // RULE2
			o_read_req     <= rd_start;                      // RULE5
			o_wr_overflow  <= wr_pix && !pix_in_ready;
			if (wr_cmd) begin
				o_cmd_byte <= d3_ff;                         // RULE2
			end
			if (rd_start) begin
				o_read_is_data <= dc3_ff;
			end
		end
	end

	// drive the bus only during an active read strobe
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_host_data_bus    <= `OHPP_RD_RESET;
			o_host_data_bus_oe <= 1'b0;
		end else begin
			o_host_data_bus_oe <= rd_act;                    // RULE5
			if (rd_act) begin
				o_host_data_bus <= i_read_data;              // RULE4
			end
		end
	end

	// display data passes through the fifo to the pixel sink
	wire              pix_valid_w;
	wire [DATA_W-1:0] pix_data_w;
	wire              fifo_pop_ready;
	assign fifo_pop_ready = !o_pix_valid || i_pix_ready;

	ohpp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rstn      (i_rstn),
		.i_in_valid  (wr_pix),
		.o_in_ready  (pix_in_ready),
		.i_in_data   (d3_ff),
		.o_out_valid (pix_valid_w),
		.i_out_ready (fifo_pop_ready),
		.o_out_data  (pix_data_w)
	);

	// registered output stage of the pixel stream
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pix_valid <= 1'b0;
			o_pix_byte  <= '0;
		end else if (fifo_pop_ready) begin
			o_pix_valid <= pix_valid_w;                      // RULE1
			o_pix_byte  <= pix_data_w;
		end
	end
endmodule

// *** verif/ohpp_port_props.sv ***
// assertions on the parallel host port outputs
`timescale 1ns/10ps
module ohpp_port_props #(parameter int DATA_W = 8) (
	input wire logic              i_clk,
	input wire logic              i_rstn,
	input wire logic              i_cs_n,
	input wire logic              i_pix_ready,
	input wire logic              o_host_data_bus_oe,
	input wire logic              o_read_req,
	input wire logic              o_cmd_valid,
	input wire logic [DATA_W-1:0] o_cmd_byte,
	input wire logic              o_pix_valid,
	input wire logic [DATA_W-1:0] o_pix_byte,
	input wire ohpp_pkg::ohpp_mode_t o_mode
);
	import ohpp_pkg::*;
	logic [3:0] cs_hi_ff;
	wire  [3:0] nxt_cs_hi = !i_cs_n ? 4'h0 : cs_hi_ff + {3'h0, cs_hi_ff != 4'hf};
	wire        par = o_mode inside {OHPP_MODE_P68, OHPP_MODE_P80};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// cycles since chip select went idle
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cs_hi_ff <= 4'hf;
		end else begin
			cs_hi_ff <= nxt_cs_hi;
		end
	end
	sequence s_rd_on; o_read_req; endsequence
	sequence s_rd_off; !o_host_data_bus_oe; endsequence
	property p_rd_end; s_rd_on |-> ##[1:20] s_rd_off; endproperty
	property p_rd_rise; $rose(o_host_data_bus_oe) |-> o_read_req; endproperty
	property p_rd_oe; o_read_req |-> o_host_data_bus_oe && par; endproperty
	property p_cmd; o_cmd_valid |-> par ##1 !o_cmd_valid; endproperty
	property p_cmd_hold; $changed(o_cmd_byte) |-> o_cmd_valid; endproperty
	property p_pix; o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_byte); endproperty
	property p_cs; cs_hi_ff > 4'hb |-> !o_cmd_valid && !o_read_req && !o_host_data_bus_oe; endproperty
	property p_ser; !par |-> !o_cmd_valid && !o_read_req; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read drive stuck");
	a_rd_rise: assert property (p_rd_rise) else $error("drive without read");
	a_rd_oe: assert property (p_rd_oe) else $error("read not driven");
	a_cmd: assert property (p_cmd) else $error("bad command pulse");
	a_cmd_hold: assert property (p_cmd_hold) else $error("command byte moved");
	a_pix: assert property (p_pix) else $error("pixel dropped");
	a_cs: assert property (p_cs) else $error("activity while deselected");
	a_ser: assert property (p_ser) else $error("activity in serial mode");
endmodule
bind ohpp_port ohpp_port_props #(.DATA_W(DATA_W)) i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_cs_n(i_cs_n), .i_pix_ready(i_pix_ready), .o_host_data_bus_oe(o_host_data_bus_oe),
	.o_read_req(o_read_req), .o_cmd_valid(o_cmd_valid), .o_cmd_byte(o_cmd_byte),
	.o_pix_valid(o_pix_valid), .o_pix_byte(o_pix_byte), .o_mode(o_mode));

// *** verif/ohpp_host.sv ***
// host controller model driving the port pins
`timescale 1ns/10ps
module ohpp_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_bus,
	output logic            o_cs_n,
	output logic            o_dc,
	output logic            o_e_rd,
	output logic            o_rw_wr,
	output logic      [7:0] o_bus,
	output logic      [7:0] o_rd_val
);
	logic p80 = 1'b0;
	initial {o_cs_n, o_dc, o_e_rd, o_rw_wr, o_bus, o_rd_val} = {4'h8, 16'h0};
	// idle strobe levels; serial modes keep both low
	task automatic idle(input logic m80);
		p80 = m80;
		o_e_rd <= m80;
		o_rw_wr <= m80;
	endtask
	// one byte; sel_n high keeps the chip deselected
	task automatic xfer(input logic sel_n, rd, dc, input logic [7:0] d);
		@(posedge i_clk);
		o_cs_n <= sel_n;
		o_dc <= dc;
		o_bus <= rd ? ~d : d;
		if (!p80) o_rw_wr <= rd;
		repeat (2) @(posedge i_clk);
		if (!p80) o_e_rd <= 1'b1;
		else if (rd) o_e_rd <= 1'b0;
		else o_rw_wr <= 1'b0;
		repeat (8) @(posedge i_clk);
		o_rd_val <= i_bus;
		o_e_rd <= p80;
		if (p80) o_rw_wr <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_bus <= ~d;
		o_rw_wr <= p80;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

// *** verif/ohpp_port_tb.sv ***
// bench for the parallel host port
`timescale 1ns/10ps
module ohpp_port_tb;
	import ohpp_pkg::*;
	logic       clk = 0, rstn = 0, sa = 0, sb = 0, rdy = 1;
	logic       cs_n, dc, e_rd, rw_wr, oe, rq, ris, cv, pv, ovf;
	logic [7:0] hb, db, rv, cb, pb, lc;
	logic [7:0] rdat = 8'h5a;
	wire  [7:0] bus = oe ? db : hb;
	ohpp_mode_t mode;
	int         n_fail = 0, compares = 0, nc = 0, no = 0, nr = 0, n;
	logic [7:0] q[$];
	ohpp_port i_dut (.i_clk(clk), .i_rstn(rstn), .i_interface_select_a(sa),
		.i_interface_select_b(sb), .i_cs_n(cs_n), .i_dc(dc), .i_strobe_e_rd(e_rd),
		.i_strobe_rw_wr(rw_wr), .i_host_data_bus(bus), .o_host_data_bus(db),
		.o_host_data_bus_oe(oe), .i_read_data(rdat), .o_read_req(rq), .o_read_is_data(ris),
		.o_cmd_valid(cv), .o_cmd_byte(cb), .o_pix_valid(pv), .i_pix_ready(rdy),
		.o_pix_byte(pb), .o_wr_overflow(ovf), .o_mode(mode));
	ohpp_host i_host (.i_clk(clk), .i_bus(bus), .o_cs_n(cs_n), .o_dc(dc), .o_e_rd(e_rd),
		.o_rw_wr(rw_wr), .o_bus(hb), .o_rd_val(rv));
	initial forever #20 clk = ~clk;
	// count commands, overflows and accepted pixels
	always @(posedge clk) begin
		if (cv === 1'b1) begin
			nc++;
			lc = cb;
		end
		if (ovf === 1'b1) no++;
		if (rq === 1'b1) nr++;
		if (pv === 1'b1 && rdy === 1'b1) q.push_back(pb);
	end
	task automatic chk(input logic [8:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic set_mode(input logic a, b);
		@(posedge clk);
		sa <= a;
		sb <= b;
		i_host.idle(!a && b);
		repeat (8) @(posedge clk);
	endtask
	task automatic t_modes;
		logic [1:0] sel[4] = '{2'b10, 2'b00, 2'b11, 2'b01};
		ohpp_mode_t em[4] = '{OHPP_MODE_SPI3, OHPP_MODE_SPI4, OHPP_MODE_P68, OHPP_MODE_P80};
		for (int i = 0; i < 4; i++) begin
			set_mode(sel[i][1], sel[i][0]);
			chk(mode, em[i]);
			n = nc;
			if (i < 2) i_host.xfer(0, 0, 0, 8'h11);
			chk(nc, n);
		end
	endtask
	task automatic t_rw;
		int r;
		n = nc;
		r = nr;
		i_host.xfer(0, 0, 0, 8'h3c);
		chk(nc, n + 1);
		chk(lc, 8'h3c);
		q.delete();
		i_host.xfer(0, 0, 1, 8'ha5);
		chk(q.size(), 1);
		chk(q[0], 8'ha5);
		rdat <= 8'h5a;
		i_host.xfer(0, 1, 1, 8'h00);
		chk(rv, 8'h5a);
		chk(ris, 1);
		chk(nr, r + 1);
		rdat <= 8'hc3;
		i_host.xfer(0, 1, 0, 8'h00);
		chk(ris, 0);
		chk(rv, 8'hc3);
		i_host.xfer(1, 0, 0, 8'h77);
		chk(nc, n + 1);
		i_host.xfer(1, 1, 0, 8'h00);
		chk(nr, r + 2);
	endtask
	task automatic t_fifo;
		q.delete();
		rdy <= 0;
		for (int i = 0; i < 6; i++) i_host.xfer(0, 0, 1, 8'h10 + i[7:0]);
		chk(no != 0, 1);
		rdy <= 1;
		repeat (12) @(posedge clk);
		chk(q.size() + no, 6);
		chk(q[0], 8'h10);
	endtask
	task automatic print_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		t_modes;
		t_rw;
		set_mode(1, 1);
		t_rw;
		set_mode(0, 1);
		t_fifo;
		print_verdict;
	end
endmodule
